/* core/cfe_error_flags.sv */
// Module: error interrupt flags of a CAN FD controller, APB slave
`timescale 1ns/1ps

// Notes on behaviour
// - Any access to an unmapped address sets flag bit 29.
// - Data-phase error code becoming neither 0 nor 7 sets bit 28.
// - Nominal error code becoming neither 0 nor 7 sets bit 27.
// - Message RAM ready missing past the watchdog limit sets bit 26.
// - Any bus-off status change, entry or exit, sets bit 25.
// - Any error-warning status change sets bit 24.
// - Any error-passive status change sets bit 23.
// - Error logging counter overflow sets bit 22.
// - Uncorrected RAM error forces the initialization bit to one.
// - Checker error input bit 0 marks corrected error, sets bit 20.
// - Initialization bit halts bus activity; bus-off entry sets it.
module cfe_error_flags
  import cfe_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  dataPhaseLastErrorCode,
  input  wire logic [2:0]  nominalLastErrorCode,
  input  wire logic        busOff,
  input  wire logic        errorWarning,
  input  wire logic        errorPassive,
  input  wire logic        errorLogOverflow,
  input  wire logic        ramRequest,
  input  wire logic        ramReady,
  input  wire logic [1:0]  ramBitError,
  output logic             irq,
  output logic             busHalt
);

  // ==========================================================
  // Registers
  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;
  logic        initBit_r;
  logic        initBit_nxt;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        irq_r;
  cfe_wd_type  wdState_r;
  cfe_wd_type  wdState_nxt;
  logic [7:0]  wdCnt_r;
  logic [7:0]  wdCnt_nxt;

  // ==========================================================
  // Bus decode
  wire         accSetup;
  wire         accDone;
  wire         hitCtrl;
  wire         hitFlags;
  wire         hitMask;
  wire         addrHit;
  wire         wrFlags;
  wire         wrMask;
  wire         wrCtrl;
  wire  [31:0] laneMask;
  wire  [31:0] readMux;

  assign accSetup = psel & penable & ~pready_r;
  assign accDone  = psel & penable & pready_r;
  assign hitCtrl  = paddr == CFE_CTRL_ADDR;
  assign hitFlags = paddr == CFE_FLAGS_ADDR;
  assign hitMask  = paddr == CFE_MASK_ADDR;
  assign addrHit  = hitCtrl | hitFlags | hitMask;
  assign wrFlags  = accDone & pwrite & hitFlags;
  assign wrMask   = accDone & pwrite & hitMask;
  assign wrCtrl   = accDone & pwrite & hitCtrl & pstrb[0];
  assign laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                     {8{pstrb[1]}}, {8{pstrb[0]}}};

  assign readMux  = hitFlags ? flags_r :
                    hitMask  ? mask_r :
                    hitCtrl  ? {31'h0000_0000, initBit_r} :
                    32'h0000_0000;

  // ==========================================================
  // Change detectors
  wire  [2:0]  dataCodeChg;
  wire  [2:0]  nomCodeChg;
  wire  [2:0]  statChg;

  cfe_change_det #(.W(3)) uDataCode (
    .clock   (clock),
    .sys_rst (sys_rst),
    .level   (dataPhaseLastErrorCode),
    .changed (dataCodeChg)
  );

  cfe_change_det #(.W(3)) uNomCode (
    .clock   (clock),
    .sys_rst (sys_rst),
    .level   (nominalLastErrorCode),
    .changed (nomCodeChg)
  );

  cfe_change_det #(.W(3)) uStatus (
    .clock   (clock),
    .sys_rst (sys_rst),
    .level   ({errorPassive, errorWarning, busOff}),
    .changed (statChg)
  );

  // ==========================================================
  // Event sources
  wire         dataCodeErr;
  wire         nomCodeErr;
  wire         wdExpire;
  wire         busOffEnter;
  wire  [31:0] setVec;
  wire  [31:0] clrVec;

  assign dataCodeErr = (|dataCodeChg)
                       && dataPhaseLastErrorCode != CFE_CODE_NONE
                       && dataPhaseLastErrorCode != CFE_CODE_NOCHG;
  assign nomCodeErr  = (|nomCodeChg)
                       && nominalLastErrorCode != CFE_CODE_NONE
                       && nominalLastErrorCode != CFE_CODE_NOCHG;
  assign wdExpire = wdState_r == WD_WAIT && wdCnt_r == CFE_WD_LAST
                    && !ramReady;
  assign busOffEnter = statChg[0] & busOff;

  assign setVec[31:30]       = 2'b00;
  assign setVec[CFE_RESV_ACC_BIT] = accDone & ~addrHit;
  assign setVec[CFE_DATA_ERR_BIT] = dataCodeErr;
  assign setVec[CFE_ARB_ERR_BIT]  = nomCodeErr;
  assign setVec[CFE_WDOG_BIT]     = wdExpire;
  assign setVec[CFE_BUSOFF_BIT]   = statChg[0];
  assign setVec[CFE_WARN_BIT]     = statChg[1];
  assign setVec[CFE_PASSIVE_BIT]  = statChg[2];
  assign setVec[CFE_LOGOVF_BIT]   = errorLogOverflow;
  assign setVec[CFE_UNCORR_BIT]   = ramBitError[1];
  assign setVec[CFE_CORR_BIT]     = ramBitError[0];
  assign setVec[19:0]        = 20'h0_0000;

  // Write one to clear; a new event wins over the clear
  assign clrVec    = wrFlags ? (pwdata & laneMask) : 32'h0000_0000;
  assign flags_nxt = ((flags_r & ~clrVec) | setVec)
                     & CFE_FLAG_MASK;
  assign mask_nxt  = wrMask ? ((mask_r & ~laneMask)
                     | (pwdata & laneMask)) & CFE_FLAG_MASK
                     : mask_r;

  // Hardware set beats a software clear
  assign initBit_nxt = (ramBitError[1] | busOffEnter) ? 1'b1 :
                       wrCtrl ? pwdata[CFE_INIT_BIT] : initBit_r;

  // ==========================================================
  // Message RAM watchdog
  always_comb begin
    wdState_nxt = wdState_r;
    wdCnt_nxt   = wdCnt_r;
    case (wdState_r)
      WD_IDLE: begin
        if (ramRequest && !ramReady) begin
          wdState_nxt = WD_WAIT;
          wdCnt_nxt   = CFE_WD_CNT_RST;
        end
      end
      WD_WAIT: begin
        if (ramReady || wdCnt_r == CFE_WD_LAST) begin
          wdState_nxt = WD_IDLE;
          wdCnt_nxt   = CFE_WD_CNT_RST;
        end else begin
          wdCnt_nxt = wdCnt_r + 8'h01;
        end
      end
      default: begin
        wdState_nxt = WD_IDLE;
        wdCnt_nxt   = CFE_WD_CNT_RST;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdState_r <= WD_IDLE;
      wdCnt_r   <= CFE_WD_CNT_RST;
    end else begin
      wdState_r <= wdState_nxt;
      wdCnt_r   <= wdCnt_nxt;
    end
  end

  // ==========================================================
  // Flag, mask and control registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags_r   <= CFE_FLAGS_RST;
      mask_r    <= CFE_MASK_RST;
      initBit_r <= CFE_INIT_RST;
    end else begin
      flags_r   <= flags_nxt;
      mask_r    <= mask_nxt;
      initBit_r <= initBit_nxt;
    end
  end

  // ==========================================================
  // APB answer, one wait state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= CFE_RDATA_RST;
    end else begin
      pready_r <= accSetup;
      if (accSetup) begin
        pslverr_r <= ~addrHit;
        prdata_r  <= pwrite ? CFE_RDATA_RST : readMux;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt output
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_r & mask_r);
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;
  assign busHalt = initBit_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_resv_acc_set: assert property (
    accDone && !addrHit |=> flags_r[CFE_RESV_ACC_BIT])
    else $error("unmapped access did not set flag 29");

  a_resv_acc_quiet: assert property (
    !flags_r[CFE_RESV_ACC_BIT] && !(accDone && !addrHit)
    |=> !flags_r[CFE_RESV_ACC_BIT])
    else $error("flag 29 set with no unmapped access");

  a_data_err_set: assert property (
    $past(dataPhaseLastErrorCode) != dataPhaseLastErrorCode
    && dataPhaseLastErrorCode inside {[3'h1:3'h6]}
    && !$past(sys_rst)
    |=> flags_r[CFE_DATA_ERR_BIT])
    else $error("data phase error did not set flag 28");

  a_arb_err_set: assert property (
    $past(nominalLastErrorCode) != nominalLastErrorCode
    && nominalLastErrorCode inside {[3'h1:3'h6]}
    && !$past(sys_rst)
    |=> flags_r[CFE_ARB_ERR_BIT])
    else $error("arbitration error did not set flag 27");

  a_wdog_start: assert property (
    wdState_r == WD_IDLE && ramRequest && !ramReady
    |=> wdState_r == WD_WAIT && wdCnt_r == CFE_WD_CNT_RST)
    else $error("watchdog did not start on missing ready");

  a_wdog_count: assert property (
    wdState_r == WD_WAIT && !ramReady && wdCnt_r != CFE_WD_LAST
    |=> wdState_r == WD_WAIT && wdCnt_r == $past(wdCnt_r) + 8'h01)
    else $error("watchdog count did not advance");

  a_wdog_expire: assert property (
    wdState_r == WD_WAIT && wdCnt_r == CFE_WD_LAST && !ramReady
    |=> flags_r[CFE_WDOG_BIT])
    else $error("watchdog flag not set after limit");

  a_busoff_chg_set: assert property (
    statChg[0] |=> flags_r[CFE_BUSOFF_BIT])
    else $error("bus-off change did not set flag 25");

  a_warn_chg_set: assert property (
    statChg[1] |=> flags_r[CFE_WARN_BIT])
    else $error("warning change did not set flag 24");

  a_passive_chg_set: assert property (
    statChg[2] |=> flags_r[CFE_PASSIVE_BIT])
    else $error("passive change did not set flag 23");

  a_logovf_set: assert property (
    errorLogOverflow |=> flags_r[CFE_LOGOVF_BIT])
    else $error("log overflow did not set flag 22");

  a_uncorr_flag_set: assert property (
    ramBitError[1] |=> flags_r[CFE_UNCORR_BIT] && busHalt)
    else $error("uncorrected error did not set flag 21");

  a_uncorr_init_force: assert property (
    ramBitError[1] |=> initBit_r ##1 (initBit_r || $past(wrCtrl)))
    else $error("uncorrected error did not force init");

  a_corr_flag_set: assert property (
    ramBitError[0] && !ramBitError[1] && !wrCtrl && !busOffEnter
    |=> flags_r[CFE_CORR_BIT] && $stable(initBit_r))
    else $error("corrected error flag or init wrong");

  a_busoff_init_set: assert property (
    $rose(busOff) && !$past(sys_rst) |=> busHalt)
    else $error("bus-off entry did not set init");

  a_flags_sticky: assert property (
    !wrFlags |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag dropped without host clear");

  a_resv_bits_zero: assert property (
    flags_r[31:30] == 2'b00 && flags_r[19:0] == 20'h0_0000)
    else $error("reserved flag bits not zero");

  a_irq_follows: assert property (
    ##1 irq == |$past(flags_r & mask_r))
    else $error("irq does not follow masked flags");

  a_pready_pulse: assert property (
    accSetup |=> pready ##1 !pready)
    else $error("pready not a single cycle answer");

  c_flag_read: cover property (accDone && !pwrite && hitFlags
                               && flags_r != 32'h0000_0000);
  c_flag_clear: cover property (wrFlags ##1 flags_r == 32'h0000_0000);
  c_irq_rise: cover property ($rose(irq));
  c_wd_expire: cover property (wdExpire);
  c_busoff_halt: cover property (busOffEnter ##1 busHalt);

endmodule

/* core/cfe_pkg.sv */
// Package: addresses, bit positions, reset values and types for cfe
package cfe_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [15:0] CFE_CTRL_ADDR  = 16'h1018;
  localparam logic [15:0] CFE_FLAGS_ADDR = 16'h1050;
  localparam logic [15:0] CFE_MASK_ADDR  = 16'h1054;

  // ==========================================================
  // Flag bit positions and the control register init bit position
  localparam int CFE_RESV_ACC_BIT = 29;
  localparam int CFE_DATA_ERR_BIT = 28;
  localparam int CFE_ARB_ERR_BIT  = 27;
  localparam int CFE_WDOG_BIT     = 26;
  localparam int CFE_BUSOFF_BIT   = 25;
  localparam int CFE_WARN_BIT     = 24;
  localparam int CFE_PASSIVE_BIT  = 23;
  localparam int CFE_LOGOVF_BIT   = 22;
  localparam int CFE_UNCORR_BIT   = 21;
  localparam int CFE_CORR_BIT     = 20;
  localparam int CFE_INIT_BIT     = 0;

  // ==========================================================
  // Implemented flag bits and reset values
  localparam logic [31:0] CFE_FLAG_MASK  = 32'h3FF0_0000;
  localparam logic [31:0] CFE_FLAGS_RST  = 32'h0000_0000;
  localparam logic [31:0] CFE_MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] CFE_RDATA_RST  = 32'h0000_0000;
  localparam logic        CFE_INIT_RST   = 1'b1;

  // ==========================================================
  // Last error codes that mean no error
  localparam logic [2:0] CFE_CODE_NONE  = 3'h0;
  localparam logic [2:0] CFE_CODE_NOCHG = 3'h7;

  // ==========================================================
  // Message RAM watchdog length in cycles
  localparam int          CFE_WD_CYCLES = 256;
  localparam logic [7:0]  CFE_WD_LAST   = 8'(CFE_WD_CYCLES - 1);
  localparam logic [7:0]  CFE_WD_CNT_RST = 8'h00;

  typedef enum logic {
    WD_IDLE,
    WD_WAIT
  } cfe_wd_type;

endpackage

/* core/cfe_change_det.sv */
// Module: per-bit change detector for status levels
`timescale 1ns/1ps

module cfe_change_det #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] changed
);

  logic [W-1:0] prev_r;
  logic         primed_r;

  // ==========================================================
  // History
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prev_r   <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r   <= level;
      primed_r <= 1'b1;
    end
  end

  // First cycle after reset only learns the level
  assign changed = primed_r ? (level ^ prev_r) : '0;

endmodule

/* tb/cfe_host_model.sv */
// Host processor model: APB master that reads and clears the flags
`timescale 1ns/1ps

module cfe_host_model (
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [15:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // ====================
  // One transfer, bounded wait for pready
  task automatic transfer(input logic w, input logic [15:0] a,
                          input logic [31:0] d, input logic [3:0] s,
                          output logic [31:0] rd,
                          output logic err, output logic ok);
    ok = 1'h0;
    rd = 32'h0000_0000;
    err = 1'h0;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'h1;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clock);
      if (pready === 1'h1) begin
        ok = 1'h1;
        rd = prdata;
        err = pslverr;
      end
    end
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* tb/can_fd_error_interrupt_flags_tb.sv */
// Testbench for the CAN FD error interrupt flag block
`timescale 1ns/1ps

module can_fd_error_interrupt_flags_tb
  import cfe_pkg::*;
;
  // ====================
  // Signals
  logic        clock = 1'h0;
  logic        sysRst = 1'h1;
  logic        psel, penable, pwrite, pready, pslverr, irq, busHalt;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [3:0]  pstrb;
  logic [3:0]  busStrb = 4'hF;
  logic [31:0] expFlags;
  logic [2:0]  dCode = 3'h0, nCode = 3'h0, nd, nn;
  logic        busOff = 1'h0, errWarn = 1'h0, errPass = 1'h0;
  logic        logOvf = 1'h0, ramReq = 1'h0, ramRdy = 1'h1, rdErr;
  logic [1:0]  ramErr = 2'h0;
  logic [15:0] lfsr = 16'h000C;
  int          numErrors = 0;
  int          numChecks = 0;

  always #4 clock = ~clock;

  cfe_host_model u_cfe_host_model (
    .clock   (clock),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  cfe_error_flags u_cfe_error_flags (
    .clock                  (clock),
    .sys_rst                (sysRst),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .pstrb                  (pstrb),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .dataPhaseLastErrorCode (dCode),
    .nominalLastErrorCode   (nCode),
    .busOff                 (busOff),
    .errorWarning           (errWarn),
    .errorPassive           (errPass),
    .errorLogOverflow       (logOvf),
    .ramRequest             (ramReq),
    .ramReady               (ramRdy),
    .ramBitError            (ramErr),
    .irq                    (irq),
    .busHalt                (busHalt)
  );

  // ====================
  // Helpers
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    lfsrNext = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] bitOf(input int p);
    bitOf = 32'h0000_0001 << p;
  endfunction

  function automatic logic [31:0] codeFlags(input logic [2:0] od, nd,
                                            input logic [2:0] on, nn);
    codeFlags = 32'h0000_0000;
    if (nd != od && nd != 3'h0 && nd != 3'h7)
      codeFlags[CFE_DATA_ERR_BIT] = 1'h1;
    if (nn != on && nn != 3'h0 && nn != 3'h7)
      codeFlags[CFE_ARB_ERR_BIT] = 1'h1;
  endfunction

  task automatic completeRun();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, exp, input string what);
    numChecks = numChecks + 1;
    if (got !== exp) begin
      numErrors = numErrors + 1;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    logic ok;
    u_cfe_host_model.transfer(w, a, d, busStrb, rdData, rdErr, ok);
    if (ok !== 1'h1) begin
      numErrors = numErrors + 1;
      $display("[ERR] %0t bus transfer not answered", $time);
      completeRun();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic expectFlags(input logic [31:0] exp);
    bus(1'h0, CFE_FLAGS_ADDR, 32'h0000_0000);
    check(rdData, exp, "flags");
    bus(1'h1, CFE_FLAGS_ADDR, 32'hFFFF_FFFF);
  endtask

  // ====================
  // Main sequence
  initial begin
    tick(3);
    sysRst <= 1'h0;
    bus(1'h0, CFE_CTRL_ADDR, 32'h0000_0000);
    check(rdData, 32'h0000_0001, "ctrl");
    expectFlags(32'h0000_0000);
    bus(1'h1, CFE_MASK_ADDR, 32'hFFFF_FFFF);
    bus(1'h0, CFE_MASK_ADDR, 32'h0000_0000);
    check(rdData, 32'h3FF0_0000, "mask");
    bus(1'h0, 16'h1040, 32'h0000_0000);
    check({rdData[30:0], rdErr}, 32'h0000_0001, "unmapped");
    tick(2);
    check({31'h0, irq}, 32'h0000_0001, "irq");
    expectFlags(bitOf(CFE_RESV_ACC_BIT));
    tick(2);
    check({31'h0, irq}, 32'h0000_0000, "irq clear");
    bus(1'h1, CFE_MASK_ADDR, 32'h0000_0000);
    bus(1'h1, CFE_CTRL_ADDR, 32'h0000_0000);
    tick(1);
    check({31'h0, busHalt}, 32'h0000_0000, "halt");
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsrNext(lfsr);
      nd = (i % 6 == 0) ? dCode : lfsr[2:0];
      nn = (i % 8 == 5) ? 3'h7 : lfsr[5:3];
      expFlags = codeFlags(dCode, nd, nCode, nn);
      @(posedge clock);
      dCode <= nd;
      nCode <= nn;
      tick(2);
      expectFlags(expFlags);
    end
    for (int k = 0; k < 3; k++) begin
      for (int v = 1; v >= 0; v--) begin
        @(posedge clock);
        if (k == 0) busOff <= v[0];
        else if (k == 1) errWarn <= v[0];
        else errPass <= v[0];
        tick(2);
        if (k == 0) check({31'h0, busHalt}, 32'h0000_0001, "halt bo");
        expectFlags(bitOf(CFE_BUSOFF_BIT - k));
      end
    end
    bus(1'h1, CFE_CTRL_ADDR, 32'h0000_0000);
    @(posedge clock);
    logOvf <= 1'h1;
    @(posedge clock);
    logOvf <= 1'h0;
    tick(2);
    check({31'h0, irq}, 32'h0000_0000, "irq masked");
    busStrb = 4'h8;
    bus(1'h1, CFE_FLAGS_ADDR, 32'hFFFF_FFFF);
    busStrb = 4'hF;
    expectFlags(bitOf(CFE_LOGOVF_BIT));
    for (int e = 0; e < 2; e++) begin
      @(posedge clock);
      ramErr <= 2'(1 << e);
      @(posedge clock);
      ramErr <= 2'h0;
      tick(2);
      check({31'h0, busHalt}, 32'(e), "halt ram");
      expectFlags(bitOf(CFE_CORR_BIT + e));
    end
    for (int w = 0; w < 2; w++) begin
      @(posedge clock);
      ramRdy <= 1'h0;
      ramReq <= 1'h1;
      @(posedge clock);
      ramReq <= 1'h0;
      tick(w == 0 ? 200 : 240);
      ramRdy <= (w == 0);
      tick(w == 0 ? 100 : 2);
      expectFlags(32'h0000_0000);
      tick(30);
      expectFlags(w == 0 ? 32'h0000_0000 : bitOf(CFE_WDOG_BIT));
      ramRdy <= 1'h1;
    end
    completeRun();
  end
endmodule
